// *** common/seq_pkg.sv ***
// Constants, types and decoders for the start-up delay sequencer
// Contract
// - Check stored configuration for about 5-10 ms.
// - Then sample strap pins before declaring ready.
// - Accept bus and enable only after loading.
// - Ignore enable and bus while loading.
// - Restore command repeats the stored-configuration check.
// - Delay timer starts when enable asserts.
// - Delays below 2 ms become 2 ms.
// - Longer delays wait the full configured time.
// - After delay, ramp over strap-selected ramp time.
// - Ramp strictly monotonic with fixed slope.
// - Two three-level pins select nine delays.
// - Tied-on enable still waits for loading stages.
// - Precise delay timing only when config bit set.
// - Trim mode maps second pin to target table.
// - Trim mode when 110k sensed on pin a.
// - Strap pins read only at start-up or restore.
package seq_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] MEMCHK_MS  = 8'h08;
    localparam logic [7:0] MIN_DLY_MS = 8'h02;

    localparam logic [3:0] RAMP_MS_LOW  = 4'h0;
    localparam logic [3:0] RAMP_MS_OPEN = 4'h5;
    localparam logic [3:0] RAMP_MS_HIGH = 4'hA;

    localparam logic [1:0] PIN_LOW  = 2'h0;
    localparam logic [1:0] PIN_OPEN = 2'h1;
    localparam logic [1:0] PIN_HIGH = 2'h2;

    localparam logic [4:0] TRIM_LAST = 5'h1A;

    typedef enum logic [2:0] {
        ST_MEMCHK  = 3'h0,
        ST_PINSAMP = 3'h1,
        ST_READY   = 3'h3,
        ST_DELAY   = 3'h2,
        ST_RAMP    = 3'h6,
        ST_ON      = 3'h7
    } seq_state_e;

    function automatic logic [1:0] pin_level(input logic [1:0] p);
        pin_level = (p == 2'h3) ? PIN_HIGH : p;
    endfunction

    function automatic logic [7:0] delay_decode(input logic [1:0] row,
                                                input logic [1:0] col);
        case ({pin_level(row), pin_level(col)})
            4'h0:    delay_decode = 8'h00;
            4'h1:    delay_decode = 8'h01;
            4'h2:    delay_decode = 8'h02;
            4'h4:    delay_decode = 8'h05;
            4'h5:    delay_decode = 8'h0A;
            4'h6:    delay_decode = 8'h14;
            4'h8:    delay_decode = 8'h32;
            4'h9:    delay_decode = 8'h64;
            4'hA:    delay_decode = 8'hC8;
            default: delay_decode = 8'h00;
        endcase
    endfunction

    function automatic logic [12:0] std_vout(input logic [1:0] row,
                                             input logic [1:0] col);
        case ({pin_level(row), pin_level(col)})
            4'h0:    std_vout = 13'h0258;
            4'h1:    std_vout = 13'h0320;
            4'h2:    std_vout = 13'h03E8;
            4'h4:    std_vout = 13'h04B0;
            4'h5:    std_vout = 13'h05DC;
            4'h6:    std_vout = 13'h0708;
            4'h8:    std_vout = 13'h09C4;
            4'h9:    std_vout = 13'h0CE4;
            4'hA:    std_vout = 13'h1388;
            default: std_vout = 13'h0258;
        endcase
    endfunction

    function automatic logic [12:0] trim_vout(input logic [4:0] idx);
        case (idx)
            5'h00: trim_vout = 13'h02BC;
            5'h01: trim_vout = 13'h02F0;
            5'h02: trim_vout = 13'h02F6;
            5'h03: trim_vout = 13'h02FD;
            5'h04: trim_vout = 13'h0304;
            5'h05: trim_vout = 13'h0316;
            5'h06: trim_vout = 13'h0320;
            5'h07: trim_vout = 13'h0335;
            5'h08: trim_vout = 13'h0342;
            5'h09: trim_vout = 13'h0350;
            5'h0A: trim_vout = 13'h0370;
            5'h0B: trim_vout = 13'h0383;
            5'h0C: trim_vout = 13'h0397;
            5'h0D: trim_vout = 13'h03C5;
            5'h0E: trim_vout = 13'h03DF;
            5'h0F: trim_vout = 13'h03E8;
            5'h10: trim_vout = 13'h044C;
            5'h11: trim_vout = 13'h0486;
            5'h12: trim_vout = 13'h04B0;
            5'h13: trim_vout = 13'h04E2;
            5'h14: trim_vout = 13'h05DC;
            5'h15: trim_vout = 13'h0685;
            5'h16: trim_vout = 13'h0708;
            5'h17: trim_vout = 13'h08F7;
            5'h18: trim_vout = 13'h09CA;
            5'h19: trim_vout = 13'h0CE4;
            default: trim_vout = 13'h1388;
        endcase
    endfunction

    function automatic logic [3:0] ramp_decode(input logic [1:0] p);
        case (pin_level(p))
            PIN_LOW:  ramp_decode = RAMP_MS_LOW;
            PIN_OPEN: ramp_decode = RAMP_MS_OPEN;
            default:  ramp_decode = RAMP_MS_HIGH;
        endcase
    endfunction

endpackage

// *** src/ramp_gen.sv ***
// Monotonic reference ramp from zero to target in millisecond steps
`timescale 1ns/100ps
module ramp_gen
    import seq_pkg::*;
(
    input  wire logic        clock,      // System clock
    input  wire logic        rst_n,      // Async reset, active low
    input  wire logic        start,      // Pulse: begin ramp
    input  wire logic        abort,      // Pulse: drop reference to zero
    input  wire logic        tick,       // Millisecond tick
    input  wire logic [3:0]  ramp_ms,    // Ramp time in ms
    input  wire logic [12:0] target_mv,  // Final reference
    output logic      [12:0] ref_mv,     // Present reference
    output logic             done        // Level: reference at target
);

    logic [12:0] ref_r;
    logic [12:0] goal_r;
    logic [12:0] step_r;
    logic [3:0]  elapsed_r;
    logic        run_r;
    logic        done_r;

    assign ref_mv = ref_r;
    assign done   = done_r;

    // Fixed step per ms; last step lands exactly on target
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_r     <= 13'h0000;
            goal_r    <= 13'h0000;
            step_r    <= 13'h0000;
            elapsed_r <= 4'h0;
            run_r     <= 1'b0;
            done_r    <= 1'b0;
        end else if (abort) begin
            ref_r  <= 13'h0000;
            run_r  <= 1'b0;
            done_r <= 1'b0;
        end else if (start) begin
            goal_r    <= target_mv;
            step_r    <= (ramp_ms == RAMP_MS_OPEN) ? target_mv / 13'h5
                                                   : target_mv / 13'hA;
            elapsed_r <= 4'h0;
            if (ramp_ms == RAMP_MS_LOW) begin
                ref_r  <= target_mv;
                run_r  <= 1'b0;
                done_r <= 1'b1;
            end else begin
                ref_r  <= 13'h0000;
                run_r  <= 1'b1;
                done_r <= 1'b0;
            end
        end else if (run_r && tick) begin
            if (elapsed_r + 4'h1 >= ramp_ms) begin
                ref_r  <= goal_r;
                run_r  <= 1'b0;
                done_r <= 1'b1;
            end else begin
                ref_r     <= ref_r + step_r;
                elapsed_r <= elapsed_r + 4'h1;
            end
        end
    end

    property p_ramp_monotonic;
        @(posedge clock) disable iff (!rst_n)
        (run_r && !abort) |=> (ref_r >= $past(ref_r));
    endproperty
    a_ramp_monotonic: assert property (p_ramp_monotonic)
        else $error("ramp reference moved down");

    property p_ramp_done_target;
        @(posedge clock) disable iff (!rst_n)
        $rose(done_r) |-> (ref_r == goal_r);
    endproperty
    a_ramp_done_target: assert property (p_ramp_done_target)
        else $error("ramp ended off target");

endmodule

// *** src/startup_delay_sequencer.sv ***
// Start-up sequencer: memory check, strap sampling, delay and ramp
`timescale 1ns/100ps
module startup_delay_sequencer
    import seq_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES  // Clock cycles per millisecond
)(
    input  wire logic        clock,                  // 100 MHz clock
    input  wire logic        rst_n,                  // Power-on reset, low
    input  wire logic        enable_in,              // Enable, active high
    input  wire logic        bus_restore,            // Pulse: restore cmd
    input  wire logic        bus_delay_wr,           // Pulse: write delay
    input  wire logic [7:0]  bus_delay_ms,           // Delay written, ms
    input  wire logic        precise_delay_en,       // Misc config bit
    input  wire logic        nvm_valid,              // Stored delay exists
    input  wire logic [7:0]  nvm_delay_ms,           // Stored delay, ms
    input  wire logic [1:0]  delay_select_pin_a,     // Column level
    input  wire logic [1:0]  delay_select_pin_b,     // Row level
    input  wire logic [1:0]  ramp_select_pin,        // Ramp time level
    input  wire logic [1:0]  voltage_select_pin_a,   // Vout column level
    input  wire logic [1:0]  voltage_select_pin_b,   // Vout row level
    input  wire logic        voltage_select_pin_a_trim, // 110k sensed
    input  wire logic [4:0]  voltage_select_pin_b_code, // Trim index
    input  wire logic        alt_trim_standard,      // 1 alt, 0 base trim
    output logic             ready,                  // Bus/enable accepted
    output logic             ramp_active,            // Ramp in progress
    output logic             output_on,              // Ramp complete
    output logic      [2:0]  seq_state,              // State code
    output logic      [7:0]  delay_cfg_ms,           // Configured delay
    output logic      [12:0] vout_target_mv,         // Target voltage
    output logic      [12:0] vout_ref_mv,            // Ramp reference
    output logic             trim_mode,              // Trim mode latched
    output logic             trim_alt                // Alt standard latched
);

    localparam int TICK_W = $clog2(MS_CYCLES_P + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES_P - 1);

    seq_state_e        state_r;
    seq_state_e        state_nxt;
    logic [TICK_W-1:0] tick_cnt_r;
    logic              tick;
    logic [7:0]        phase_cnt_r;
    logic [7:0]        dly_cfg_r;
    logic [7:0]        pin_dly_r;
    logic              nvm_hit_r;
    logic [7:0]        nvm_dly_r;
    logic              precise_r;
    logic [3:0]        ramp_ms_r;
    logic [12:0]       target_r;
    logic              trim_mode_r;
    logic              trim_alt_r;
    logic [7:0]        eff_dly;
    logic [8:0]        dly_goal;
    logic              accept;
    logic              enter_memchk;
    logic              enter_delay;
    logic              ramp_start;
    logic              ramp_abort;
    logic              ramp_done;

    assign accept = (state_r == ST_READY) || (state_r == ST_DELAY) ||
                    (state_r == ST_RAMP)  || (state_r == ST_ON);
    assign tick   = (tick_cnt_r == TICK_LAST);
    assign eff_dly = (dly_cfg_r < MIN_DLY_MS) ? MIN_DLY_MS
                                              : dly_cfg_r;
    // Ordinary timing adds one tick so that a free tick never shortens it
    assign dly_goal = precise_r ? {1'b0, eff_dly}
                                : {1'b0, eff_dly} + 9'h001;

    assign enter_memchk = (state_nxt == ST_MEMCHK) && (state_r != ST_MEMCHK);
    assign enter_delay  = (state_nxt == ST_DELAY) && (state_r != ST_DELAY);
    assign ramp_start   = (state_r == ST_DELAY) && (state_nxt == ST_RAMP);
    assign ramp_abort   = ((state_r == ST_RAMP) || (state_r == ST_ON)) &&
                          (state_nxt != ST_RAMP) && (state_nxt != ST_ON);

    // Sequence: memory check, pin sample, ready, delay, ramp, on
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_MEMCHK: begin
                if (tick && (phase_cnt_r == MEMCHK_MS - 8'h01)) begin
                    state_nxt = ST_PINSAMP;
                end
            end
            ST_PINSAMP: begin
                state_nxt = ST_READY;
            end
            ST_READY: begin
                if (bus_restore) begin
                    state_nxt = ST_MEMCHK;
                end else if (enable_in) begin
                    state_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (bus_restore) begin
                    state_nxt = ST_MEMCHK;
                end else if (!enable_in) begin
                    state_nxt = ST_READY;
                end else if (tick &&
                             ({1'b0, phase_cnt_r} + 9'h001 >= dly_goal)) begin
                    state_nxt = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (bus_restore) begin
                    state_nxt = ST_MEMCHK;
                end else if (!enable_in) begin
                    state_nxt = ST_READY;
                end else if (ramp_done) begin
                    state_nxt = ST_ON;
                end
            end
            ST_ON: begin
                if (bus_restore) begin
                    state_nxt = ST_MEMCHK;
                end else if (!enable_in) begin
                    state_nxt = ST_READY;
                end
            end
            default: state_nxt = ST_MEMCHK;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_MEMCHK;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Millisecond prescaler, realigned at check start and precise delay
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= '0;
        end else if (enter_memchk ||
                     (enter_delay && precise_delay_en)) begin
            tick_cnt_r <= '0;
        end else if (tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + TICK_W'(1);
        end
    end

    // Milliseconds spent in the present state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_cnt_r <= 8'h00;
        end else if (state_nxt != state_r) begin
            phase_cnt_r <= 8'h00;
        end else if (tick && (phase_cnt_r != 8'hFF)) begin
            phase_cnt_r <= phase_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            precise_r <= 1'b0;
        end else if (enter_delay) begin
            precise_r <= precise_delay_en;
        end
    end

    // Stored values caught at the end of the memory check
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nvm_hit_r <= 1'b0;
            nvm_dly_r <= 8'h00;
        end else if ((state_r == ST_MEMCHK) &&
                     (state_nxt == ST_PINSAMP)) begin
            nvm_hit_r <= nvm_valid;
            nvm_dly_r <= nvm_delay_ms;
        end
    end

    // Straps read only in the sampling state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_dly_r   <= 8'h00;
            ramp_ms_r   <= RAMP_MS_LOW;
            target_r    <= 13'h0000;
            trim_mode_r <= 1'b0;
            trim_alt_r  <= 1'b0;
        end else if (state_r == ST_PINSAMP) begin
            pin_dly_r   <= delay_decode(delay_select_pin_b,
                                        delay_select_pin_a);
            ramp_ms_r   <= ramp_decode(ramp_select_pin);
            trim_mode_r <= voltage_select_pin_a_trim;
            trim_alt_r  <= alt_trim_standard;
            if (voltage_select_pin_a_trim) begin
                target_r <= (voltage_select_pin_b_code > TRIM_LAST)
                            ? trim_vout(TRIM_LAST)
                            : trim_vout(voltage_select_pin_b_code);
            end else begin
                target_r <= std_vout(voltage_select_pin_b,
                                     voltage_select_pin_a);
            end
        end
    end

    // Delay setting: stored value wins over straps, bus writes after ready
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dly_cfg_r <= 8'h00;
        end else if (state_r == ST_PINSAMP) begin
            dly_cfg_r <= nvm_hit_r ? nvm_dly_r
                                   : delay_decode(delay_select_pin_b,
                                                  delay_select_pin_a);
        end else if (accept && bus_delay_wr) begin
            dly_cfg_r <= bus_delay_ms;
        end
    end

    ramp_gen u_ramp (
        .clock     (clock),
        .rst_n     (rst_n),
        .start     (ramp_start),
        .abort     (ramp_abort),
        .tick      (tick),
        .ramp_ms   (ramp_ms_r),
        .target_mv (target_r),
        .ref_mv    (vout_ref_mv),
        .done      (ramp_done)
    );

    assign ready          = accept;
    assign ramp_active    = (state_r == ST_RAMP);
    assign output_on      = (state_r == ST_ON);
    assign seq_state      = state_r;
    assign delay_cfg_ms   = dly_cfg_r;
    assign vout_target_mv = target_r;
    assign trim_mode      = trim_mode_r;
    assign trim_alt       = trim_alt_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_load_ignores_en;
        (state_r == ST_MEMCHK || state_r == ST_PINSAMP)
            |-> !ready && (state_nxt != ST_DELAY);
    endproperty
    a_load_ignores_en: assert property (p_load_ignores_en)
        else $error("enable or bus seen during loading");

    property p_memchk_length;
        (state_r == ST_MEMCHK) && (state_nxt == ST_PINSAMP)
            |-> (phase_cnt_r == MEMCHK_MS - 8'h01) && tick;
    endproperty
    a_memchk_length: assert property (p_memchk_length)
        else $error("memory check left early");

    property p_pins_then_ready;
        (state_r == ST_PINSAMP) |=> (state_r == ST_READY) &&
            ($past(state_r, 2) == ST_MEMCHK) &&
            (nvm_hit_r || (dly_cfg_r == pin_dly_r));
    endproperty
    a_pins_then_ready: assert property (p_pins_then_ready)
        else $error("pin sampling out of order");

    property p_restore;
        accept && bus_restore |=> (state_r == ST_MEMCHK) && !ready;
    endproperty
    a_restore: assert property (p_restore)
        else $error("restore did not rerun memory check");

    property p_delay_start;
        (state_r == ST_READY) && enable_in && !bus_restore
            |=> (state_r == ST_DELAY) && (phase_cnt_r == 8'h00);
    endproperty
    a_delay_start: assert property (p_delay_start)
        else $error("delay did not start on enable");

    property p_min_delay;
        (state_r == ST_DELAY) && (state_nxt == ST_RAMP)
            |-> ({1'b0, phase_cnt_r} + 9'h001 >= {1'b0, MIN_DLY_MS});
    endproperty
    a_min_delay: assert property (p_min_delay)
        else $error("delay shorter than minimum");

    property p_full_delay;
        (state_r == ST_DELAY) && (state_nxt == ST_RAMP)
            |-> ({1'b0, phase_cnt_r} + 9'h001 == dly_goal);
    endproperty
    a_full_delay: assert property (p_full_delay)
        else $error("delay not equal to configured time");

    property p_ramp_follows_delay;
        $rose(ramp_active) |-> ($past(state_r) == ST_DELAY) ##1
            (vout_ref_mv <= target_r);
    endproperty
    a_ramp_follows_delay: assert property (p_ramp_follows_delay)
        else $error("ramp began without delay");

    property p_enable_drop;
        (state_r == ST_DELAY || state_r == ST_RAMP) && !enable_in &&
            !bus_restore |=> (state_r == ST_READY) && (phase_cnt_r == 8'h00);
    endproperty
    a_enable_drop: assert property (p_enable_drop)
        else $error("enable drop not handled");

    property p_precise_align;
        (state_r == ST_READY) && enable_in && !bus_restore &&
            precise_delay_en |=> (tick_cnt_r == '0);
    endproperty
    a_precise_align: assert property (p_precise_align)
        else $error("precise delay not aligned to enable");

    property p_pins_frozen;
        (state_r != ST_PINSAMP) |=> $stable(pin_dly_r) && $stable(target_r);
    endproperty
    a_pins_frozen: assert property (p_pins_frozen)
        else $error("strap settings changed after sampling");

    property p_trim_mode;
        (state_r == ST_PINSAMP) |=> (trim_mode_r == $past(
            voltage_select_pin_a_trim));
    endproperty
    a_trim_mode: assert property (p_trim_mode)
        else $error("trim mode not latched");

    c_reach_on:     cover property ($rose(output_on));
    c_enable_drop:  cover property ((state_r == ST_DELAY) ##1
                                    (state_r == ST_READY));
    c_restore:      cover property ((state_r == ST_ON) ##1
                                    (state_r == ST_MEMCHK));
    c_trim_ramp:    cover property (trim_mode_r && ramp_active);

endmodule

// *** verif/strap_model.sv ***
// Enable source and delay strap resistor model
`timescale 1ns/100ps
module strap_model (
    input  wire logic       clock,       // System clock
    input  wire logic [3:0] sel,         // Row and column level
    input  wire logic       en_req,      // Requested enable
    output logic            en,          // Enable pin
    output logic      [1:0] pin_a,       // Delay column level
    output logic      [1:0] pin_b        // Delay row level
);
    assign pin_a = sel[1:0];
    assign pin_b = sel[3:2];
    // Clock source assumed stable before enable rises
    always @(posedge clock) begin
        en <= en_req;
    end
endmodule

// *** verif/test_startup_delay_sequencer.sv ***
// Random and corner tests of the start-up delay sequencer
`timescale 1ns/100ps
module test_startup_delay_sequencer import seq_pkg::*;;
    logic clock = 0, rst_n = 0, en_req = 1, rst_cmd = 0, dwr = 0;
    logic prec = 0, trim = 0, alt = 0, en, ready, ramp_active, output_on;
    logic [7:0]  dms = 0, cfg, nvm_d = 0;
    logic        nvm_v = 0, tm, ta;
    logic [1:0]  vpa = 0, vpb = 0, rsel = 0, pa, pb;
    logic [4:0]  code = 0;
    logic [3:0]  sel = 0;
    logic [2:0]  seq_state;
    logic [12:0] tgt, vref;
    int          error_cnt = 0, num_checks = 0, n;
    strap_model u_strap (.clock(clock), .sel(sel), .en_req(en_req),
        .en(en), .pin_a(pa), .pin_b(pb));
    startup_delay_sequencer #(.MS_CYCLES_P(20)) u_dut (.clock(clock),
        .rst_n(rst_n), .enable_in(en), .bus_restore(rst_cmd),
        .bus_delay_wr(dwr), .bus_delay_ms(dms), .precise_delay_en(prec),
        .nvm_valid(nvm_v), .nvm_delay_ms(nvm_d), .delay_select_pin_a(pa),
        .delay_select_pin_b(pb), .ramp_select_pin(rsel),
        .voltage_select_pin_a(vpa), .voltage_select_pin_b(vpb),
        .voltage_select_pin_a_trim(trim), .voltage_select_pin_b_code(code),
        .alt_trim_standard(alt), .ready(ready), .ramp_active(ramp_active),
        .output_on(output_on), .seq_state(seq_state), .delay_cfg_ms(cfg),
        .vout_target_mv(tgt), .vout_ref_mv(vref), .trim_mode(tm),
        .trim_alt(ta));
    always #5 clock = ~clock;
    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, s);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask
    function automatic logic [7:0] exp_dly(input logic [3:0] s);
        logic [7:0] t[9] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h0A, 8'h14,
                             8'h32, 8'h64, 8'hC8};
        return t[s[3:2] * 3 + s[1:0]];
    endfunction
    function automatic int lv(input logic [1:0] p);
        return (p == 2'h3) ? 2 : int'(p);
    endfunction
    function automatic logic [12:0] exp_vout(input logic [1:0] a, b,
        input logic [4:0] c, input logic t);
        logic [12:0] sv[9] = '{13'h0258, 13'h0320, 13'h03E8, 13'h04B0,
            13'h05DC, 13'h0708, 13'h09C4, 13'h0CE4, 13'h1388};
        logic [12:0] tv[27] = '{13'h02BC, 13'h02F0, 13'h02F6, 13'h02FD,
            13'h0304, 13'h0316, 13'h0320, 13'h0335, 13'h0342, 13'h0350,
            13'h0370, 13'h0383, 13'h0397, 13'h03C5, 13'h03DF, 13'h03E8,
            13'h044C, 13'h0486, 13'h04B0, 13'h04E2, 13'h05DC, 13'h0685,
            13'h0708, 13'h08F7, 13'h09CA, 13'h0CE4, 13'h1388};
        if (t) return tv[(c > 5'h1A) ? 5'h1A : c];
        return sv[lv(b) * 3 + lv(a)];
    endfunction
    task automatic wait_ready();
        n = 0;
        while (ready !== 1'b1 && n < 400) begin
            chk("early", 0, 16'(ramp_active));
            step(1);
            n++;
        end
        chk("rdy", 1, 16'(ready));
    endtask
    task automatic restore();
        rst_cmd = 1'b1;
        step(1);
        rst_cmd = 1'b0;
        step(1);
        chk("rst", 0, 16'(ready));
        wait_ready();
    endtask
    task automatic run(input logic [7:0] d);
        logic [12:0] last;
        int dd, r;
        dd = (d < 8'h02) ? 2 : int'(d);
        r = (rsel == 2'h0) ? 0 : (rsel == 2'h1) ? 5 : 10;
        chk("tgt", 16'(exp_vout(vpa, vpb, code, trim)), 16'(tgt));
        chk("trim", 16'(trim), 16'(tm));
        chk("alt", 16'(alt), 16'(ta));
        en_req = 1'b1;
        n = 0;
        while (ramp_active !== 1'b1 && n < 5000) begin
            step(1);
            n++;
        end
        if (prec)
            chk("pdly", 16'(dd*20+2), 16'(n));
        else
            chk("dly", 1, n >= dd*20+3 && n <= dd*20+22);
        last = 0;
        n = 0;
        while (output_on !== 1'b1 && n < 300) begin
            chk("mono", 1, 16'(vref >= last));
            last = vref;
            step(1);
            n++;
        end
        chk("ramp", 16'(r*20+1), 16'(n));
        chk("ref", 16'(tgt), 16'(vref));
        en_req = 1'b0;
        step(3);
        chk("off", 16'(ST_READY), 16'(seq_state));
        chk("ref0", 0, 16'(vref));
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #300000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'hbfc8));
        step(8);
        rst_n = 1'b1;
        dms = 8'h55;
        dwr = 1'b1;
        step(1);
        dwr = 1'b0;
        wait_ready();
        chk("load", 1, n >= 155 && n <= 165);
        chk("cfg0", 16'(exp_dly(sel)), 16'(cfg));
        run(cfg);
        nvm_v = 1'b1;
        nvm_d = 8'h03 + 8'($urandom % 8);
        restore();
        chk("nvm", 16'(nvm_d), 16'(cfg));
        run(cfg);
        nvm_v = 1'b0;
        for (int i = 0; i < 9; i++) begin
            sel = {2'(i / 3), 2'(i % 3)};
            rsel = 2'($urandom % 3);
            prec = 1'($urandom);
            {vpa, vpb, code, trim, alt} = 11'($urandom);
            restore();
            chk("cfg", 16'(exp_dly(sel)), 16'(cfg));
            run(cfg);
        end
        sel = 4'h0;
        step(5);
        chk("hold", 16'h00C8, 16'(cfg));
        dms = 8'($urandom % 6);
        dwr = 1'b1;
        step(1);
        dwr = 1'b0;
        step(1);
        chk("wr", 16'(dms), 16'(cfg));
        run(dms);
        en_req = 1'b1;
        step(10);
        en_req = 1'b0;
        step(3);
        chk("abort", 16'(ST_READY), 16'(seq_state));
        report_and_stop();
    end
endmodule
